/* File: logic/interval_timer_bus_and_counters.sv */
// Host bus, configuration word and three 16-bit down counters of an interval timer.
// Assumes host strobes synchronous to mclk; counter clock and gate pins are asynchronous.
// Contract
// - Strobes act only while the active-low chip select is low.
// - Address 00,01,10 pick counters 0..2; 11 picks configuration word.
// - Data bus is driven only during a selected read.
// - Write to address 11 stores and interprets a configuration command.
// - Configuration word is write-only; seen only via latched status.
// - Three identical counters, each independently configured.
// - Each counter is a 16-bit presettable down counter on its own clock.
// - Count is read through high and low byte output latches.
// - Latched status holds configuration, output level and null count flag.
// - Each counter has its own gate, clock and output pins.
// - Output latches track until latch command, hold until read, then resume.
// - Count bytes held, loaded both at once; cleared on reprogramming.
`timescale 1ns/1ns
`default_nettype none
`include "interval_timer_cfg.svh"
module interval_timer_bus_and_counters #(
  parameter int NUM_COUNTERS = 3
) (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic chipSelect_n, // Chip select, active low
  input wire logic readStrobe_n, // Read strobe, active low
  input wire logic writeStrobe_n, // Write strobe, active low
  input wire logic [1:0] port_select_bits, // Port address
  input wire logic [7:0] hostDataIn, // Data bus input
  output logic [7:0] hostDataOut, // Data bus output
  output logic hostDataOe, // Data bus drive enable
  input wire logic [2:0] cntClk, // Counter clock pins
  input wire logic [2:0] cntGate, // Counter gate pins
  output logic [2:0] cntOut // Counter output pins
);
  if (NUM_COUNTERS != 3) begin : g_bad_count
    $error("NUM_COUNTERS must be 3");
  end

  // ==========================================================
  // Strobe qualification and edge detection
  logic rdLevel;
  logic wrLevel;
  logic rdPrev_r;
  logic wrPrev_r;
  logic rdEnd;
  logic wrEnd;
  assign rdLevel = !chipSelect_n && !readStrobe_n;
  assign wrLevel = !chipSelect_n && !writeStrobe_n;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdPrev_r <= 1'b0;
      wrPrev_r <= 1'b0;
    end else begin
      rdPrev_r <= rdLevel;
      wrPrev_r <= wrLevel;
    end
  end
  // Act once per access, on the trailing edge
  assign rdEnd = rdPrev_r && !rdLevel;
  assign wrEnd = wrPrev_r && !wrLevel;

  logic [1:0] addrHold_r;
  logic [7:0] dataHold_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      addrHold_r <= 2'h0;
      dataHold_r <= 8'h00;
    end else if (rdLevel || wrLevel) begin
      addrHold_r <= port_select_bits;
      dataHold_r <= hostDataIn;
    end
  end

  logic cfgWrite;
  logic isReadback;
  assign cfgWrite = wrEnd && (addrHold_r == `PORT_CONFIG);
  assign isReadback = dataHold_r[`CW_SC_HI:`CW_SC_LO] == `SC_READBACK;

  // ==========================================================
  // Counters
  logic [7:0] readByte [3];
  logic [2:0] readDone;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cnt
      logic [2:0] clkSync_r;
      logic [1:0] gateSync_r;
      logic clkRise;
      logic [5:0] cw_r;
      logic [15:0] ce_r;
      logic [15:0] ol_r;
      logic [15:0] count_load_register;
      logic latched_r;
      logic msbNext_r;
      logic wrMsbNext_r;
      logic loadPend_r;
      logic nullCount_r;
      logic outLvl_r;
      logic [7:0] status_r;
      logic statusLatched_r;
      logic sel;
      logic rbSel;
      logic progCmd;
      logic latchCmd;
      logic cntWrite;
      interval_timer_pkg::access_e acc;

      assign sel = dataHold_r[`CW_SC_HI:`CW_SC_LO] == 2'(gi);
      assign rbSel = isReadback && dataHold_r[gi + 1];
      assign progCmd = cfgWrite && sel && (dataHold_r[`CW_RW_HI:`CW_RW_LO] != 2'h0);
      assign latchCmd = cfgWrite && ((sel && dataHold_r[`CW_RW_HI:`CW_RW_LO] == 2'h0)
                        || (rbSel && !dataHold_r[`RB_NOCOUNT]));
      assign cntWrite = wrEnd && (addrHold_r == 2'(gi));
      assign readDone[gi] = rdEnd && (addrHold_r == 2'(gi));
      assign acc = interval_timer_pkg::access_e'(cw_r[5:4]);

      always_ff @(posedge mclk) begin
        if (rst) begin
          clkSync_r <= 3'h0;
          gateSync_r <= 2'h0;
        end else begin
          clkSync_r <= {clkSync_r[1:0], cntClk[gi]};
          gateSync_r <= {gateSync_r[0], cntGate[gi]};
        end
      end
      assign clkRise = clkSync_r[1] && !clkSync_r[2];

      // Configuration held internally, never read back directly
      always_ff @(posedge mclk) begin
        if (rst) begin
          cw_r <= `CW_RESET;
        end else if (progCmd) begin
          cw_r <= dataHold_r[5:0];
        end
      end

      // Count register writes, cleared on reprogramming
      always_ff @(posedge mclk) begin
        if (rst) begin
          count_load_register <= `CNT_RESET;
          wrMsbNext_r <= 1'b0;
          loadPend_r <= 1'b0;
        end else if (progCmd) begin
          count_load_register <= `CNT_RESET;
          wrMsbNext_r <= 1'b0;
          loadPend_r <= 1'b0;
        end else begin
          if (cntWrite) begin
            unique case (acc)
              interval_timer_pkg::ACC_LSB: begin
                count_load_register[7:0] <= dataHold_r;
                loadPend_r <= 1'b1;
              end
              interval_timer_pkg::ACC_MSB: begin
                count_load_register[15:8] <= dataHold_r;
                loadPend_r <= 1'b1;
              end
              interval_timer_pkg::ACC_WORD: begin
                if (wrMsbNext_r) begin
                  count_load_register[15:8] <= dataHold_r;
                  loadPend_r <= 1'b1;
                end else begin
                  count_load_register[7:0] <= dataHold_r;
                end
                wrMsbNext_r <= !wrMsbNext_r;
              end
              interval_timer_pkg::ACC_LATCH: begin
              end
            endcase
          end else if (clkRise && loadPend_r) begin
            loadPend_r <= 1'b0;
          end
        end
      end

      // Down counter on own clock, gate enables
      always_ff @(posedge mclk) begin
        if (rst) begin
          ce_r <= `CNT_RESET;
        end else if (clkRise) begin
          if (loadPend_r) begin
            ce_r <= count_load_register;
          end else if (gateSync_r[1]) begin
            ce_r <= ce_r - 16'h0001;
          end
        end
      end

      // Null count set on count write, cleared when loaded; a new write wins
      always_ff @(posedge mclk) begin
        if (rst) begin
          nullCount_r <= 1'b1;
        end else if (progCmd || cntWrite) begin
          nullCount_r <= 1'b1;
        end else if (clkRise && loadPend_r) begin
          nullCount_r <= 1'b0;
        end
      end

      // Output pin: high while counter is at zero and no count is pending
      always_ff @(posedge mclk) begin
        if (rst) begin
          outLvl_r <= 1'b0;
        end else begin
          outLvl_r <= (ce_r == 16'h0000) && !nullCount_r;
        end
      end
      assign cntOut[gi] = outLvl_r;

      // Output latch follows until latched, released after read
      always_ff @(posedge mclk) begin
        if (rst) begin
          ol_r <= `CNT_RESET;
          latched_r <= 1'b0;
        end else if (latchCmd && !latched_r) begin
          latched_r <= 1'b1;
        end else if (!latched_r) begin
          ol_r <= ce_r;
        end else if (readDone[gi] && !statusLatched_r && (acc != interval_timer_pkg::ACC_WORD
                     || msbNext_r)) begin
          latched_r <= 1'b0;
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          status_r <= 8'h00;
          statusLatched_r <= 1'b0;
        end else if (cfgWrite && rbSel && !dataHold_r[`RB_NOSTATUS] && !statusLatched_r) begin
          status_r <= {outLvl_r, nullCount_r, cw_r};
          statusLatched_r <= 1'b1;
        end else if (progCmd || readDone[gi]) begin
          statusLatched_r <= 1'b0;
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          msbNext_r <= 1'b0;
        end else if (progCmd) begin
          msbNext_r <= 1'b0;
        end else if (readDone[gi] && !statusLatched_r && acc == interval_timer_pkg::ACC_WORD) begin
          msbNext_r <= !msbNext_r;
        end
      end

      always_comb begin
        if (statusLatched_r) begin
          readByte[gi] = status_r;
        end else if (acc == interval_timer_pkg::ACC_MSB
                     || (acc == interval_timer_pkg::ACC_WORD && msbNext_r)) begin
          readByte[gi] = ol_r[15:8];
        end else begin
          readByte[gi] = ol_r[7:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read data path
  // Drive only during a selected counter read
  always_ff @(posedge mclk) begin
    if (rst) begin
      hostDataOut <= 8'h00;
      hostDataOe <= 1'b0;
    end else begin
      hostDataOe <= rdLevel && (port_select_bits != `PORT_CONFIG);
      unique case (port_select_bits)
        `PORT_CNT0: hostDataOut <= readByte[0];
        `PORT_CNT1: hostDataOut <= readByte[1];
        `PORT_CNT2: hostDataOut <= readByte[2];
        `PORT_CONFIG: hostDataOut <= 8'h00;
      endcase
    end
  end
endmodule : interval_timer_bus_and_counters
`default_nettype wire

/* File: logic/interval_timer_cfg.svh */
// Offsets, field positions and reset values for the interval timer bus block.
// Assumes nothing; definitions only.
`ifndef INTERVAL_TIMER_CFG_SVH
`define INTERVAL_TIMER_CFG_SVH
`define PORT_CNT0 2'h0
`define PORT_CNT1 2'h1
`define PORT_CNT2 2'h2
`define PORT_CONFIG 2'h3
`define CW_SC_HI 7
`define CW_SC_LO 6
`define CW_RW_HI 5
`define CW_RW_LO 4
`define CW_MODE_HI 3
`define CW_MODE_LO 1
`define CW_BCD 0
`define SC_READBACK 2'h3
`define RB_NOCOUNT 5
`define RB_NOSTATUS 4
`define CW_RESET 6'h00
`define CNT_RESET 16'h0000
`endif

/* File: logic/interval_timer_pkg.sv */
// Types shared by the interval timer bus block.
// Assumes the configuration header for numeric constants.
`default_nettype none
package interval_timer_pkg;
  typedef enum logic [1:0] {
    ACC_LATCH = 2'h0,
    ACC_LSB = 2'h1,
    ACC_MSB = 2'h2,
    ACC_WORD = 2'h3
  } access_e;
endpackage : interval_timer_pkg
`default_nettype wire

/* File: test/interval_timer_props.sv */
// Bound checks on the timer host bus and counter pins.
// Assumes it is bound into the top design module.
`timescale 1ns/1ns
`default_nettype none
module interval_timer_props (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic chipSelect_n, // select
  input wire logic readStrobe_n, // read
  input wire logic writeStrobe_n, // write
  input wire logic [1:0] port_select_bits, // port
  input wire logic [7:0] hostDataOut, // data
  input wire logic hostDataOe, // enable
  input wire logic [2:0] cntClk, // clocks
  input wire logic [2:0] cntOut // outputs
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic rdSel;
  logic [3:0] quiet_r;
  assign rdSel = !chipSelect_n && !readStrobe_n && port_select_bits != 2'h3;
  // Cycles since a counter clock was last high
  always_ff @(posedge mclk) begin
    if (rst || |cntClk) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  end
  chk_oe_cause: assert property (hostDataOe |-> $past(rdSel))
    else $error("stray drive");
  chk_oe_follow: assert property (rdSel |=> hostDataOe)
    else $error("read not driven");
  chk_cs_gate: assert property (chipSelect_n [*2] |-> !hostDataOe)
    else $error("drive while deselected");
  chk_cfg_unread: assert property (!chipSelect_n && !readStrobe_n &&
    port_select_bits == 2'h3 |=> !hostDataOe) else $error("config word read");
  chk_write_dark: assert property (!chipSelect_n && !writeStrobe_n && readStrobe_n
    |=> !hostDataOe) else $error("drive during write");
  chk_reset_idle: assert property ($fell(rst) |-> !hostDataOe && cntOut == 3'h0)
    else $error("outputs not idle");
  chk_out_cause: assert property ((cntOut & ~$past(cntOut)) != 3'h0 |-> quiet_r < 4'hC)
    else $error("output rose without clock");
  chk_data_hold: assert property (hostDataOe && $past(hostDataOe) &&
    $stable(port_select_bits) && quiet_r > 4'h8 |-> $stable(hostDataOut))
    else $error("read data moved");
endmodule : interval_timer_props
bind interval_timer_bus_and_counters interval_timer_props chk (.mclk(mclk), .rst(rst),
  .chipSelect_n(chipSelect_n), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
  .port_select_bits(port_select_bits), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
  .cntClk(cntClk), .cntOut(cntOut));
`default_nettype wire

/* File: test/interval_timer_host.sv */
// Host processor model on the timer's peripheral bus.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ns
`default_nettype none
module interval_timer_host (
  input wire logic mclk, // clock
  input wire logic [7:0] hostDataOut, // read data
  input wire logic hostDataOe, // drive enable
  output logic chipSelect_n, // select
  output logic readStrobe_n, // read
  output logic writeStrobe_n, // write
  output logic [1:0] port_select_bits, // port
  output logic [7:0] hostDataIn // write data
);
  initial {chipSelect_n, readStrobe_n, writeStrobe_n, port_select_bits, hostDataIn} = 13'h1C00;
  task automatic wr(input logic [1:0] a, input logic [7:0] dt, input logic sel);
    @(posedge mclk) #1 {chipSelect_n, writeStrobe_n, port_select_bits, hostDataIn} =
      {!sel, 1'b0, a, dt};
    @(posedge mclk) #1 {chipSelect_n, writeStrobe_n, hostDataIn} = {2'h3, ~dt};
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic sel, output logic [7:0] dt,
    output logic en);
    @(posedge mclk) #1 {chipSelect_n, readStrobe_n, port_select_bits} = {!sel, 1'b0, a};
    repeat (2) @(posedge mclk);
    #1 {dt, en} = {hostDataOut, hostDataOe};
    {chipSelect_n, readStrobe_n} = 2'h3;
    @(posedge mclk);
  endtask : rd
endmodule : interval_timer_host
`default_nettype wire

/* File: test/interval_timer_bus_and_counters_test.sv */
// Self-checking bench for the interval timer bus and counters.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module interval_timer_bus_and_counters_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] cntClk = 3'h0, cntGate = 3'h0, cntOut;
  logic chipSelect_n, readStrobe_n, writeStrobe_n, hostDataOe, oe;
  logic [1:0] port_select_bits;
  logic [7:0] hostDataIn, hostDataOut, b, d;
  logic [15:0] v, cnt;
  logic [15:0] ex [3];
  logic [3:0] k;
  int seed = 95447;
  int n_fail = 0;
  int comparisons = 0;
  interval_timer_host h (.mclk(mclk), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .chipSelect_n(chipSelect_n), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
    .port_select_bits(port_select_bits), .hostDataIn(hostDataIn));
  interval_timer_bus_and_counters uut (.mclk(mclk), .rst(rst), .chipSelect_n(chipSelect_n),
    .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
    .port_select_bits(port_select_bits), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .cntClk(cntClk), .cntGate(cntGate), .cntOut(cntOut));
  always #2 mclk = ~mclk;
  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Counter clock pulses, four system clocks high, five low between pulses
  task automatic pulse(input int n, input int num);
    repeat (num) begin
      @(posedge mclk) #1 cntClk[n] = 1'b1;
      repeat (4) @(posedge mclk);
      #1 cntClk[n] = 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask : pulse
  task automatic grab(input logic [1:0] n, output logic [15:0] r);
    h.wr(2'h3, {n, 6'h00}, 1'b1);
    h.rd(n, 1'b1, r[7:0], oe);
    h.rd(n, 1'b1, r[15:8], oe);
  endtask : grab
  function automatic logic [15:0] less(input logic [15:0] c, input logic [3:0] t);
    return c - {12'h000, t};
  endfunction : less
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    `CHK({hostDataOe, cntOut}, 4'h0)
    for (logic [1:0] n = 2'h0; n != 2'h3; n++) begin
      cnt = 16'($random(seed)) | 16'h0101;
      k = 4'($random(seed) & 7) + 4'h1;
      h.wr(2'h3, {n, 6'h30}, 1'b1);
      h.wr(n, cnt[7:0], 1'b1);
      h.wr(n, cnt[15:8], 1'b1);
      pulse(n, 1);
      grab(n, v);
      `CHK(v, cnt)
      h.wr(2'h3, 8'hE0 | (8'h02 << n), 1'b1);
      h.rd(n, 1'b1, b, oe);
      `CHK(b, 8'h30)
      #1 cntGate[n] = 1'b1;
      pulse(n, k);
      grab(n, v);
      `CHK(v, less(cnt, k))
      h.wr(2'h3, {n, 6'h00}, 1'b1);
      pulse(n, 2);
      h.rd(n, 1'b1, v[7:0], oe);
      h.rd(n, 1'b1, v[15:8], oe);
      `CHK(v, less(cnt, k))
      #1 cntGate[n] = 1'b0;
      ex[n] = less(cnt, k + 4'h2);
      h.wr(n, 8'h00, 1'b0);
      h.wr(n, 8'h00, 1'b0);
      pulse(n, 1);
      grab(n, v);
      `CHK(v, ex[n])
    end
    for (logic [1:0] n = 2'h0; n != 2'h3; n++) begin
      grab(n, v);
      `CHK(v, ex[n])
    end
    h.rd(2'h3, 1'b1, b, oe);
    `CHK(oe, 1'b0)
    // Readback count latch on all three counters, then read each word
    h.wr(2'h3, 8'hDE, 1'b1);
    for (logic [1:0] n = 2'h0; n != 2'h3; n++) begin
      h.rd(n, 1'b1, v[7:0], oe);
      h.rd(n, 1'b1, v[15:8], oe);
      `CHK(v, ex[n])
    end
    for (logic [1:0] r = 2'h1; r != 2'h3; r++) begin
      d = (r == 2'h1) ? 8'h01 : 8'($random(seed)) | 8'h02;
      h.wr(2'h3, {2'h1, r, 4'h0}, 1'b1);
      h.wr(2'h1, d, 1'b1);
      pulse(1, 1);
      #1 cntGate[1] = 1'b1;
      pulse(1, 1);
      #1 cntGate[1] = 1'b0;
      `CHK(cntOut[1], r == 2'h1)
      h.wr(2'h3, 8'h40, 1'b1);
      h.rd(2'h1, 1'b1, b, oe);
      `CHK(b, d - 8'h01)
      `CHK(oe, 1'b1)
    end
    tally_and_finish();
  end
endmodule : interval_timer_bus_and_counters_test
`default_nettype wire
